// >>> rtl/vcc_chk_if.sv
// Carrier between the checker top and one control-group checker.
`timescale 1ns/100ps
interface vcc_chk_if;
  vcc_pkg::vcc_ctl_t ctl;
  vcc_pkg::vcc_caps_t caps;
  logic gate;
  logic zero_viol;
  logic one_viol;
  modport grp (input ctl, input caps, input gate, output zero_viol, output one_viol);
  modport owner (output ctl, output caps, output gate, input zero_viol, input one_viol);
endinterface

// >>> rtl/vcc_consts.svh
// Constant offsets, default-one masks, bit positions and reset values of the checker.
`ifndef VCC_CONSTS_SVH
`define VCC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Capability register offsets
// ----------------------------------------------------------------------------
`define VCC_ADDR_BASIC 32'h0000_0480
`define VCC_ADDR_PIN 32'h0000_0481
`define VCC_ADDR_PRIM 32'h0000_0482
`define VCC_ADDR_EXIT 32'h0000_0483
`define VCC_ADDR_SEC 32'h0000_048B
`define VCC_ADDR_PIN_FULL 32'h0000_048D
`define VCC_ADDR_PRIM_FULL 32'h0000_048E
`define VCC_ADDR_EXIT_FULL 32'h0000_048F

// ----------------------------------------------------------------------------
// Default-one class masks
// ----------------------------------------------------------------------------
`define VCC_DEF1_PIN 32'h0000_0016
`define VCC_DEF1_PRIM 32'h0401_E172
`define VCC_DEF1_EXIT 32'h0003_6DFF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VCC_BIT_FULL_CAPS 6'h37
`define VCC_BIT_SEC_SUPPORT 6'h3F
`define VCC_BIT_SEC_ACTIVATE 5'h1F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VCC_RST_RDATA 64'h0000_0000_0000_0000
`define VCC_RST_VIOL 4'h0

`endif

// >>> rtl/vcc_group_check.sv
// Allowed-0 and allowed-1 comparison of one control word against its capability.
`timescale 1ns/100ps
module vcc_group_check (
  vcc_chk_if.grp chk
);
  // A set low-half bit demands the control be one.
  assign chk.zero_viol = chk.gate & (|(chk.caps[31:0] & ~chk.ctl)); // see R1
  // A clear high-half bit forbids the control be one.
  assign chk.one_viol = chk.gate & (|(chk.ctl & ~chk.caps[63:32])); // see R2
endmodule

// >>> rtl/vcc_pkg.sv
// Types shared by the capability checker files.
package vcc_pkg;
  typedef logic [63:0] vcc_caps_t;
  typedef logic [31:0] vcc_ctl_t;
  typedef enum {VCC_GRP_PIN, VCC_GRP_PRIM, VCC_GRP_SEC, VCC_GRP_EXIT} vcc_grp_e;
endpackage

// >>> rtl/vcc_top.sv
// Entry-time control word legality checker with read-only capability registers.
//
// Operation
// R1 - Set low-half capability bit X fails entry when control X is zero.
// R2 - Control X one with capability bit 32+X clear fails entry.
// R3 - Normal pin capability reads one at pin default-one bits 1, 2, 4.
// R4 - Full-caps bit clear: any cleared pin default-one control fails entry.
// R5 - Full-caps bit set: full registers checked on every bit, no exceptions.
// R6 - Full-caps bit clear: full registers absent, normal registers alone apply.
// R7 - Normal primary capability reads one at its default-one positions.
// R8 - Full-caps bit clear: cleared primary default-one control fails entry.
// R9 - Normal exit capability reads one at exit default-one positions.
// R10 - Full-caps bit clear: cleared exit default-one control fails entry.
// R11 - Secondary capability low half reads zero; reserved secondary controls zero.
// R12 - Secondary high half never allows one for a reserved control.
// R13 - Secondary one-violation counts only when activate-secondary control is one.
// R14 - Secondary register exists only when primary capability bit 63 is one.
// R15 - Software consults only the normal or the full register per group.
// R16 - Full-caps bit tells whether default-one controls may be zero.
// R17 - Capability writes fault; reads fault without virtualization support.
// R18 - Entry failure is the OR of every violation, in one step.
`timescale 1ns/100ps
`include "vcc_consts.svh"
module vcc_top #(
  parameter bit VIRT_SUPPORTED = 1'b1,
  // Revision field in the low bits is arbitrary.
  parameter logic [63:0] BASIC_CAPS = 64'h0080_1000_0000_0001,
  parameter logic [63:0] PIN_CAPS_RAW = 64'h0000_00FF_0000_0016,
  parameter logic [63:0] PRIM_CAPS_RAW = 64'hFFFF_FFFF_0401_E172,
  parameter logic [63:0] EXIT_CAPS_RAW = 64'h00FF_FFFF_0003_6DFF,
  parameter logic [63:0] SEC_CAPS_RAW = 64'h0000_FFFF_0000_0000,
  parameter logic [31:0] SEC_RESERVED = 32'hFFFF_0000,
  parameter logic [63:0] PIN_FULL_RAW = 64'h0000_00FF_0000_0000,
  parameter logic [63:0] PRIM_FULL_RAW = 64'hFFFF_FFFF_0000_0000,
  parameter logic [63:0] EXIT_FULL_RAW = 64'h00FF_FFFF_0000_0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic msr_req,
  input wire logic msr_we,
  input wire logic [31:0] msr_addr,
  output logic msr_ack_q,
  output logic msr_gp_q,
  output logic [63:0] msr_rdata_q,
  input wire logic entry_req,
  input wire vcc_pkg::vcc_ctl_t pin_ctl,
  input wire vcc_pkg::vcc_ctl_t prim_ctl,
  input wire vcc_pkg::vcc_ctl_t sec_ctl,
  input wire vcc_pkg::vcc_ctl_t exit_ctl,
  output logic entry_done_q,
  output logic entry_fail_q,
  output logic [3:0] grp_viol_q
);

  // --------------------------------------------------------------------------
  // Capability values as seen by software and by the checker
  // --------------------------------------------------------------------------
  function automatic vcc_pkg::vcc_caps_t pick_caps(input vcc_pkg::vcc_caps_t normal,
                                                   input vcc_pkg::vcc_caps_t full,
                                                   input logic use_full);
    pick_caps = use_full ? full : normal;
  endfunction

  function automatic vcc_pkg::vcc_caps_t force_def1(input vcc_pkg::vcc_caps_t raw,
                                                    input logic [31:0] mask);
    force_def1 = {raw[63:32], raw[31:0] | mask};
  endfunction

  logic full_on;
  logic sec_exists;
  vcc_pkg::vcc_caps_t pin_caps;
  vcc_pkg::vcc_caps_t prim_caps;
  vcc_pkg::vcc_caps_t exit_caps;
  vcc_pkg::vcc_caps_t sec_caps;

  assign full_on = BASIC_CAPS[`VCC_BIT_FULL_CAPS]; // see R16
  assign pin_caps = force_def1(PIN_CAPS_RAW, `VCC_DEF1_PIN); // see R3
  assign prim_caps = force_def1(PRIM_CAPS_RAW, `VCC_DEF1_PRIM); // see R7
  assign exit_caps = force_def1(EXIT_CAPS_RAW, `VCC_DEF1_EXIT); // see R9
  // Reserved secondary controls may only be zero.
  assign sec_caps = {SEC_CAPS_RAW[63:32] & ~SEC_RESERVED, 32'h0000_0000}; // see R11 see R12
  assign sec_exists = prim_caps[`VCC_BIT_SEC_SUPPORT]; // see R14

  // --------------------------------------------------------------------------
  // Group checkers
  // --------------------------------------------------------------------------
  vcc_chk_if chk_pin ();
  vcc_chk_if chk_prim ();
  vcc_chk_if chk_sec ();
  vcc_chk_if chk_exit ();

  // Normal registers carry the forced default-one bits, so their low-half
  // check already fails a cleared default-one control when full caps are off.
  assign chk_pin.caps = pick_caps(pin_caps, PIN_FULL_RAW, full_on); // see R4 see R5 see R6
  assign chk_prim.caps = pick_caps(prim_caps, PRIM_FULL_RAW, full_on); // see R8 see R5 see R6
  assign chk_exit.caps = pick_caps(exit_caps, EXIT_FULL_RAW, full_on); // see R10 see R5 see R6
  assign chk_sec.caps = sec_caps;
  assign chk_pin.ctl = pin_ctl;
  assign chk_prim.ctl = prim_ctl;
  assign chk_exit.ctl = exit_ctl;
  assign chk_sec.ctl = sec_ctl;
  assign chk_pin.gate = 1'b1;
  assign chk_prim.gate = 1'b1;
  assign chk_exit.gate = 1'b1;
  assign chk_sec.gate = prim_ctl[`VCC_BIT_SEC_ACTIVATE]; // see R13

  vcc_group_check u_pin (.chk(chk_pin.grp));
  vcc_group_check u_prim (.chk(chk_prim.grp));
  vcc_group_check u_sec (.chk(chk_sec.grp));
  vcc_group_check u_exit (.chk(chk_exit.grp));

  logic [3:0] viol_now;
  assign viol_now[vcc_pkg::VCC_GRP_PIN] = chk_pin.zero_viol | chk_pin.one_viol;
  assign viol_now[vcc_pkg::VCC_GRP_PRIM] = chk_prim.zero_viol | chk_prim.one_viol;
  assign viol_now[vcc_pkg::VCC_GRP_SEC] = chk_sec.zero_viol | chk_sec.one_viol;
  assign viol_now[vcc_pkg::VCC_GRP_EXIT] = chk_exit.zero_viol | chk_exit.one_viol;

  // --------------------------------------------------------------------------
  // Entry check step
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      entry_done_q <= 1'b0;
    end else begin
      entry_done_q <= entry_req;
    end
  end

  // Result holds until the next entry request.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      entry_fail_q <= 1'b0;
      grp_viol_q <= `VCC_RST_VIOL;
    end else if (entry_req) begin
      entry_fail_q <= |viol_now; // see R18
      grp_viol_q <= viol_now;
    end
  end

  // --------------------------------------------------------------------------
  // Capability register reads
  // --------------------------------------------------------------------------
  logic [63:0] rdata_d;
  logic gp_d;

  always_comb begin
    rdata_d = `VCC_RST_RDATA;
    gp_d = 1'b0;
    case (msr_addr)
      `VCC_ADDR_BASIC: rdata_d = BASIC_CAPS;
      `VCC_ADDR_PIN: rdata_d = pin_caps;
      `VCC_ADDR_PRIM: rdata_d = prim_caps;
      `VCC_ADDR_EXIT: rdata_d = exit_caps;
      `VCC_ADDR_SEC: begin
        rdata_d = sec_caps;
        gp_d = !sec_exists; // see R14
      end
      `VCC_ADDR_PIN_FULL: begin
        rdata_d = PIN_FULL_RAW;
        gp_d = !full_on; // see R6
      end
      `VCC_ADDR_PRIM_FULL: begin
        rdata_d = PRIM_FULL_RAW;
        gp_d = !full_on; // see R6
      end
      `VCC_ADDR_EXIT_FULL: begin
        rdata_d = EXIT_FULL_RAW;
        gp_d = !full_on; // see R6
      end
      default: gp_d = 1'b1;
    endcase
    // Registers are read-only and absent without virtualization support.
    if (msr_we || !VIRT_SUPPORTED) begin
      gp_d = 1'b1; // see R17
    end
    if (gp_d) begin
      rdata_d = `VCC_RST_RDATA;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      msr_ack_q <= 1'b0;
    end else begin
      msr_ack_q <= msr_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      msr_gp_q <= 1'b0;
      msr_rdata_q <= `VCC_RST_RDATA;
    end else if (msr_req) begin
      msr_gp_q <= gp_d;
      msr_rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  pin_def1_a: assert property ( // see R4
    entry_req && !full_on && ((pin_ctl & `VCC_DEF1_PIN) != `VCC_DEF1_PIN)
    |=> entry_fail_q && grp_viol_q[0])
    else $error("cleared pin default-one control did not fail entry");

  prim_def1_a: assert property ( // see R8
    entry_req && !full_on && ((prim_ctl & `VCC_DEF1_PRIM) != `VCC_DEF1_PRIM)
    |=> entry_fail_q && grp_viol_q[1])
    else $error("cleared primary default-one control did not fail entry");

  exit_def1_a: assert property ( // see R10
    entry_req && !full_on && ((exit_ctl & `VCC_DEF1_EXIT) != `VCC_DEF1_EXIT)
    |=> entry_fail_q && grp_viol_q[3])
    else $error("cleared exit default-one control did not fail entry");

  exit_one_set_a: assert property ( // see R2
    entry_req && (|(exit_ctl & ~chk_exit.caps[63:32])) |=> entry_fail_q)
    else $error("disallowed exit one-setting passed");

  pin_zero_set_a: assert property ( // see R1
    entry_req && (|(chk_pin.caps[31:0] & ~pin_ctl)) |=> entry_fail_q)
    else $error("disallowed pin zero-setting passed");

  full_no_except_a: assert property ( // see R5
    entry_req && full_on && (|(PIN_FULL_RAW[31:0] & ~pin_ctl)) |=> grp_viol_q[0])
    else $error("full pin capability check skipped a bit");

  sec_gate_a: assert property ( // see R13
    entry_req && !prim_ctl[`VCC_BIT_SEC_ACTIVATE] |=> !grp_viol_q[2])
    else $error("secondary violation raised while secondary controls inactive");

  sec_one_a: assert property ( // see R13 see R12
    entry_req && prim_ctl[`VCC_BIT_SEC_ACTIVATE] && (|(sec_ctl & SEC_RESERVED))
    |=> entry_fail_q && grp_viol_q[2])
    else $error("reserved secondary control set passed entry");

  fail_or_a: assert property ( // see R18
    entry_req |=> entry_done_q && (entry_fail_q == (|grp_viol_q)))
    else $error("entry failure is not the OR of group violations");

  ro_write_a: assert property ( // see R17
    msr_req && msr_we |=> msr_ack_q && msr_gp_q && (msr_rdata_q == 64'h0000_0000_0000_0000))
    else $error("capability write did not fault");

  no_full_a: assert property ( // see R6
    msr_req && !msr_we && !full_on && (msr_addr == `VCC_ADDR_PIN_FULL) |=> msr_gp_q)
    else $error("full capability register read without full-caps support");

  sec_exist_a: assert property ( // see R14
    msr_req && !msr_we && (msr_addr == `VCC_ADDR_SEC)
    |=> msr_gp_q == !($past(sec_exists) && VIRT_SUPPORTED))
    else $error("secondary register existence mismatch");

  sec_low_a: assert property ( // see R11
    msr_req && (msr_addr == `VCC_ADDR_SEC) |=> msr_rdata_q[31:0] == 32'h0000_0000)
    else $error("secondary low half read nonzero");

  def1_read_a: assert property ( // see R3 see R7 see R9
    msr_req && !msr_we && VIRT_SUPPORTED && (msr_addr == `VCC_ADDR_PRIM)
    |=> ((msr_rdata_q[31:0] & `VCC_DEF1_PRIM) == `VCC_DEF1_PRIM)
    && ((pin_caps[31:0] & `VCC_DEF1_PIN) == `VCC_DEF1_PIN)
    && ((exit_caps[31:0] & `VCC_DEF1_EXIT) == `VCC_DEF1_EXIT))
    else $error("default-one positions not reading as one");

  prim_one_set_a: assert property ( // see R2
    entry_req && (|(prim_ctl & ~chk_prim.caps[63:32])) |=> entry_fail_q && grp_viol_q[1])
    else $error("disallowed primary one-setting passed");

  ack_pulse_a: assert property ( // see R17
    msr_ack_q == $past(msr_req))
    else $error("register access answer not one cycle after request");

  done_pulse_a: assert property ( // see R18
    entry_done_q == $past(entry_req))
    else $error("entry answer not one cycle after request");

  fail_hold_a: assert property ( // see R18
    !entry_req |=> $stable(entry_fail_q) && $stable(grp_viol_q))
    else $error("entry result changed without a request");

  rdata_hold_a: assert property ( // see R17
    !msr_req |=> $stable(msr_rdata_q) && $stable(msr_gp_q))
    else $error("register read result changed without a request");

  gp_no_data_a: assert property ( // see R17
    msr_gp_q |-> msr_rdata_q == 64'h0000_0000_0000_0000)
    else $error("faulted access returned data");

  no_virt_a: assert property ( // see R17
    msr_req && !VIRT_SUPPORTED |=> msr_gp_q)
    else $error("capability read without virtualization support did not fault");

  full_zero_c: cover property (entry_req && full_on && (pin_ctl == 32'h0000_0000) ##1 entry_fail_q);
  entry_pass_c: cover property (entry_req ##1 entry_done_q && !entry_fail_q);
  entry_fail_c: cover property (entry_req ##1 entry_done_q && entry_fail_q);
  msr_fault_c: cover property (msr_req && msr_we ##1 msr_gp_q);
  sec_read_c: cover property (msr_req && (msr_addr == `VCC_ADDR_SEC) ##1 !msr_gp_q);

endmodule

// >>> test/vcc_sw_model.sv
// Hypervisor-side model that picks the one capability register it consults per group.
`timescale 1ns/100ps
module vcc_sw_model (
  input wire vcc_pkg::vcc_caps_t basic_caps,
  input wire vcc_pkg::vcc_caps_t norm_caps [3],
  input wire vcc_pkg::vcc_caps_t full_caps [3],
  output vcc_pkg::vcc_caps_t sel_caps [3]
);
  // ----------------------------------------------------------------------------
  // Register choice
  // ----------------------------------------------------------------------------
  // Software never mixes the two views, so one selection serves pin, primary and exit.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sel_caps[i] = basic_caps[55] ? full_caps[i] : norm_caps[i];
    end
  end
endmodule

// >>> test/vcc_top_tb.sv
// Self-checking bench for the capability checker: register reads and entry checks.
`timescale 1ns/100ps
`include "vcc_consts.svh"
module vcc_top_tb;
  // ----------------------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------------------
  localparam logic [63:0] BASIC_FULL = 64'h0080_1000_0000_0001;
  localparam logic [63:0] BASIC_NF = 64'h0000_1000_0000_0001;
  localparam logic [63:0] SEC_CAPS = 64'h0000_FFFF_0000_0000;
  localparam int LIMIT = 2000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic msr_req = 1'b0;
  logic msr_we = 1'b0;
  logic [31:0] msr_addr = 32'h0;
  logic entry_req = 1'b0;
  vcc_pkg::vcc_ctl_t pin_ctl = 32'h0, prim_ctl = 32'h0, sec_ctl = 32'h0, exit_ctl = 32'h0;
  logic ack_a, gp_a, done_a, fail_a, ack_b, gp_b, done_b, fail_b, ack_c, gp_c;
  logic [63:0] rdata_a, rdata_b, rdata_c;
  logic [3:0] viol_a, viol_b;
  vcc_pkg::vcc_caps_t norm_a [3], norm_b [3], full [3], sel_a [3], sel_b [3];
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  assign norm_a = '{{32'h0000_00FF, `VCC_DEF1_PIN}, {32'hFFFF_FFFF, `VCC_DEF1_PRIM},
                    {32'h00FF_FFFF, `VCC_DEF1_EXIT}};
  assign norm_b = '{{32'h0000_00FF, `VCC_DEF1_PIN}, {32'h7FFF_FFFF, `VCC_DEF1_PRIM},
                    {32'h00FF_FFFF, `VCC_DEF1_EXIT}};
  assign full = '{64'h0000_00FF_0000_0004, 64'hFFFF_FFFF_0000_0000, 64'h00FF_FFFF_0000_0000};

  always #4 clk = ~clk;

  // ----------------------------------------------------------------------------
  // Devices and software models
  // ----------------------------------------------------------------------------
  // The first device's full pin register still demands one default-one control.
  // The second device lacks the full registers and the secondary register.
  // The third device lacks virtualization support, so every access faults.
  vcc_top #(.PIN_FULL_RAW(64'h0000_00FF_0000_0004))
  u_vcc_top (.clk(clk), .resetn(resetn), .msr_req(msr_req), .msr_we(msr_we),
    .msr_addr(msr_addr), .msr_ack_q(ack_a), .msr_gp_q(gp_a), .msr_rdata_q(rdata_a),
    .entry_req(entry_req), .pin_ctl(pin_ctl), .prim_ctl(prim_ctl), .sec_ctl(sec_ctl),
    .exit_ctl(exit_ctl), .entry_done_q(done_a), .entry_fail_q(fail_a), .grp_viol_q(viol_a));
  vcc_top #(.BASIC_CAPS(BASIC_NF), .PIN_CAPS_RAW(64'h0000_00FF_0000_0000),
    .PRIM_CAPS_RAW(64'h7FFF_FFFF_0000_0000), .EXIT_CAPS_RAW(64'h00FF_FFFF_0000_0000))
  u_vcc_top_nf (.clk(clk), .resetn(resetn), .msr_req(msr_req), .msr_we(msr_we),
    .msr_addr(msr_addr), .msr_ack_q(ack_b), .msr_gp_q(gp_b), .msr_rdata_q(rdata_b),
    .entry_req(entry_req), .pin_ctl(pin_ctl), .prim_ctl(prim_ctl), .sec_ctl(sec_ctl),
    .exit_ctl(exit_ctl), .entry_done_q(done_b), .entry_fail_q(fail_b), .grp_viol_q(viol_b));
  vcc_top #(.VIRT_SUPPORTED(1'b0))
  u_vcc_top_nv (.clk(clk), .resetn(resetn), .msr_req(msr_req), .msr_we(msr_we),
    .msr_addr(msr_addr), .msr_ack_q(ack_c), .msr_gp_q(gp_c), .msr_rdata_q(rdata_c),
    .entry_req(entry_req), .pin_ctl(pin_ctl), .prim_ctl(prim_ctl), .sec_ctl(sec_ctl),
    .exit_ctl(exit_ctl), .entry_done_q(), .entry_fail_q(), .grp_viol_q());
  vcc_sw_model u_vcc_sw_model (.basic_caps(BASIC_FULL), .norm_caps(norm_a),
    .full_caps(full), .sel_caps(sel_a));
  vcc_sw_model u_vcc_sw_model_nf (.basic_caps(BASIC_NF), .norm_caps(norm_b),
    .full_caps(full), .sel_caps(sel_b));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic gv(input logic [31:0] ctl, input logic [63:0] caps, input logic gate);
    return (|(caps[31:0] & ~ctl)) | (gate & (|(ctl & ~caps[63:32])));
  endfunction

  task automatic acc(input logic we, input logic [31:0] a, input logic [63:0] ea, eb,
                     input logic ga, gb);
    @(negedge clk);
    msr_we = we;
    msr_addr = a;
    msr_req = 1'b1;
    @(negedge clk);
    msr_req = 1'b0;
    chk({ack_a, ack_b, ack_c}, 64'h7);
    chk(gp_c, 64'h1);
    chk(rdata_c, 64'h0);
    chk({gp_a, gp_b}, {ga, gb});
    chk(rdata_a, ea);
    chk(rdata_b, eb);
  endtask

  task automatic entry(input vcc_pkg::vcc_ctl_t p, r, s, e);
    logic [3:0] va;
    logic [3:0] vb;
    @(negedge clk);
    pin_ctl = p;
    prim_ctl = r;
    sec_ctl = s;
    exit_ctl = e;
    entry_req = 1'b1;
    @(negedge clk);
    entry_req = 1'b0;
    va = {gv(e, sel_a[2], 1'b1), gv(s, SEC_CAPS, r[31]), gv(r, sel_a[1], 1'b1),
          gv(p, sel_a[0], 1'b1)};
    vb = {gv(e, sel_b[2], 1'b1), va[2], gv(r, sel_b[1], 1'b1), gv(p, sel_b[0], 1'b1)};
    chk({done_a, done_b}, 64'h3);
    chk(viol_a, va);
    chk(fail_a, |va);
    chk(viol_b, vb);
    chk(fail_b, |vb);
  endtask

  // ----------------------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk({ack_a, gp_a, done_a, fail_a, viol_a}, 64'h0);
    chk(rdata_a, 64'h0);
    chk({ack_b, gp_b, done_b, fail_b, viol_b, ack_c, gp_c}, 64'h0);
    $display("Test reset done");
    acc(1'b0, `VCC_ADDR_BASIC, BASIC_FULL, BASIC_NF, 1'b0, 1'b0);
    acc(1'b0, `VCC_ADDR_PIN, norm_a[0], norm_b[0], 1'b0, 1'b0);
    acc(1'b0, `VCC_ADDR_PRIM, norm_a[1], norm_b[1], 1'b0, 1'b0);
    acc(1'b0, `VCC_ADDR_EXIT, norm_a[2], norm_b[2], 1'b0, 1'b0);
    acc(1'b0, `VCC_ADDR_SEC, SEC_CAPS, 64'h0, 1'b0, 1'b1);
    acc(1'b0, `VCC_ADDR_PIN_FULL, full[0], 64'h0, 1'b0, 1'b1);
    acc(1'b0, `VCC_ADDR_PRIM_FULL, full[1], 64'h0, 1'b0, 1'b1);
    acc(1'b0, `VCC_ADDR_EXIT_FULL, full[2], 64'h0, 1'b0, 1'b1);
    acc(1'b0, 32'h0000_0484, 64'h0, 64'h0, 1'b1, 1'b1);
    acc(1'b1, `VCC_ADDR_PIN, 64'h0, 64'h0, 1'b1, 1'b1);
    $display("Test register access done");
    entry(32'h0000_0016, `VCC_DEF1_PRIM, 32'h0, `VCC_DEF1_EXIT);
    entry(32'h0, 32'h0, 32'h0, 32'h0);
    entry(32'h0000_0116, `VCC_DEF1_PRIM, 32'h0, `VCC_DEF1_EXIT);
    entry(32'h0000_0016, 32'h8401_E172, 32'h0001_0000, `VCC_DEF1_EXIT);
    entry(32'h0000_0016, `VCC_DEF1_PRIM, 32'h0001_0000, 32'h0103_6DFF);
    entry(32'h0000_0016, 32'h8401_E172, 32'h0000_FFFF, `VCC_DEF1_EXIT);
    $display("Test entry checks done");
    print_verdict();
  end
endmodule
